// *** hdl/wdsw_pkg.sv ***
// package: constants and carrier types for the watchdog with sleep and wake
package wdsw_pkg;
   localparam logic [11:0] WDSW_OFS_CTL      = 12'h80c;
   localparam logic [11:0] WDSW_OFS_STATUS   = 12'h810;
   localparam logic [11:0] WDSW_OFS_IRQ_STAT = 12'h814;
   localparam logic [11:0] WDSW_OFS_IRQ_CLR  = 12'h818;
   localparam logic [11:0] WDSW_OFS_IRQ_EN   = 12'h81c;
   localparam logic [11:0] WDSW_OFS_COUNT    = 12'h820;
   localparam int          WDSW_CTL_CS_BIT   = 7;
   localparam int          WDSW_CTL_PS_MSB   = 5;
   localparam int          WDSW_CTL_PS_LSB   = 1;
   localparam int          WDSW_CTL_SEN_BIT  = 0;
   localparam logic [7:0]  WDSW_CTL_RST      = 8'h16;
   localparam logic [7:0]  WDSW_CTL_MASK     = 8'hbf;
   localparam logic [4:0]  WDSW_PS_MAX_CODE  = 5'h12;
   localparam int          WDSW_BASE_DIV     = 32;
   localparam logic [1:0]  WDSW_MODE_OFF     = 2'h0;
   localparam logic [1:0]  WDSW_MODE_SW      = 2'h1;
   localparam logic [1:0]  WDSW_MODE_AWAKE   = 2'h2;
   localparam logic [1:0]  WDSW_MODE_ALWAYS  = 2'h3;
   localparam int          WDSW_EV_W         = 4;
   localparam int          WDSW_EV_RESET     = 0;
   localparam int          WDSW_EV_WD_WAKE   = 1;
   localparam int          WDSW_EV_SLEEP     = 2;
   localparam int          WDSW_EV_SLEEP_NOP = 3;
   localparam logic [1:0]  WDSW_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  WDSW_RESP_SLVERR  = 2'h2;

   typedef enum logic [1:0] {
      WDSW_PWR_AWAKE  = 2'b00,
      WDSW_PWR_ASLEEP = 2'b01,
      WDSW_PWR_WAKING = 2'b10
   } wdsw_pwr_e;

   typedef struct packed {
      logic       kick_instruction;
      logic       sleep_instruction;
      logic       global_irq_enable;
      logic [7:0] irq_enable_vec;
      logic [7:0] irq_flag_vec;
   } wdsw_core_in_s;

   typedef struct packed {
      logic device_reset_req;
      logic asleep;
      logic cpu_clock_enable;
      logic wake;
      logic isr_after_next;
   } wdsw_core_out_s;

   typedef struct packed {
      logic timeout_flag_n;
      logic powerdown_flag_n;
      logic watchdog_reset_flag_n;
   } wdsw_flags_s;
endpackage : wdsw_pkg

// *** hdl/wdsw_watchdog.sv ***
// watchdog with sleep and wake control, axi4-lite register slave
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module wdsw_watchdog
   import wdsw_pkg::*;
#(
   parameter int CNT_W = 24
) (
   input  wire logic           clk,
   input  wire logic           rst_n,
   input  wire logic [1:0]     watchdog_mode_cfg,
   input  wire logic           low_freq_osc,
   input  wire logic           mid_freq_osc,
   input  wire wdsw_core_in_s  core_in,
   output wdsw_core_out_s      core_out,
   output wdsw_flags_s         flags,
   output logic                irq,
   input  wire logic [11:0]    s_axi_awaddr,
   input  wire logic           s_axi_awvalid,
   output logic                s_axi_awready,
   input  wire logic [31:0]    s_axi_wdata,
   input  wire logic [3:0]     s_axi_wstrb,
   input  wire logic           s_axi_wvalid,
   output logic                s_axi_wready,
   output logic [1:0]          s_axi_bresp,
   output logic                s_axi_bvalid,
   input  wire logic           s_axi_bready,
   input  wire logic [11:0]    s_axi_araddr,
   input  wire logic           s_axi_arvalid,
   output logic                s_axi_arready,
   output logic [31:0]         s_axi_rdata,
   output logic [1:0]          s_axi_rresp,
   output logic                s_axi_rvalid,
   input  wire logic           s_axi_rready
);

   typedef struct packed {
      logic [7:0]           ctl;
      logic [CNT_W-1:0]     cnt;
      wdsw_pwr_e            pwr;
      wdsw_flags_s          flg;
      logic [1:0]           mode;
      logic                 mode_taken;
      logic [2:0]           lf_sync;
      logic [2:0]           mf_sync;
      logic                 lf_filt;
      logic                 mf_filt;
      logic [WDSW_EV_W-1:0] ev_stat;
      logic [WDSW_EV_W-1:0] ev_en;
      logic                 reset_req;
      logic                 wake;
      logic                 isr_after;
      logic                 aw_full;
      logic [11:0]          aw_addr;
      logic                 w_full;
      logic [31:0]          wdata;
      logic [3:0]           wstrb;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
   } wdsw_state_s;

   wdsw_state_s q_ff;
   wdsw_state_s nxt_q;

   // last count value before timeout for a prescale code
   function automatic logic [CNT_W-1:0] ratio_last(input logic [4:0] ps);
      if (ps > WDSW_PS_MAX_CODE) begin
         ratio_last = CNT_W'(WDSW_BASE_DIV - 1);
      end else begin
         ratio_last = CNT_W'((WDSW_BASE_DIV << ps) - 1);
      end
   endfunction

   function automatic logic wd_active(input logic [1:0] mode, input logic sw_watchdog_enable,
                                      input logic asleep);
      case (mode)
         WDSW_MODE_ALWAYS: wd_active = 1'b1;
         WDSW_MODE_AWAKE:  wd_active = !asleep;
         WDSW_MODE_SW:     wd_active = sw_watchdog_enable;
         WDSW_MODE_OFF:    wd_active = 1'b0;
         default:          wd_active = 1'b0;
      endcase
   endfunction

   function automatic logic rising_tick(input logic [2:0] sync, input logic filt);
      rising_tick = (sync[1] == sync[2]) && sync[1] && !filt;
   endfunction

   function automatic logic is_mapped(input logic [11:0] addr);
      is_mapped = (addr == WDSW_OFS_CTL) || (addr == WDSW_OFS_STATUS) ||
                  (addr == WDSW_OFS_IRQ_STAT) || (addr == WDSW_OFS_IRQ_CLR) ||
                  (addr == WDSW_OFS_IRQ_EN) || (addr == WDSW_OFS_COUNT);
   endfunction

   logic [4:0]       ps;
   logic             sw_watchdog_enable;
   logic             tick;
   logic             asleep;
   logic             active;
   logic             timeout;
   logic             pending;
   logic             wr_fire;
   logic             ctl_wr;
   logic [CNT_W-1:0] last;
   logic [WDSW_EV_W-1:0] ev_set;
   logic [WDSW_EV_W-1:0] ev_clr;

   assign ps      = q_ff.ctl[WDSW_CTL_PS_MSB:WDSW_CTL_PS_LSB];
   assign sw_watchdog_enable     = q_ff.ctl[WDSW_CTL_SEN_BIT];
   assign tick    = q_ff.ctl[WDSW_CTL_CS_BIT] ? rising_tick(q_ff.mf_sync, q_ff.mf_filt)
                                              : rising_tick(q_ff.lf_sync, q_ff.lf_filt);
   assign asleep  = (q_ff.pwr == WDSW_PWR_ASLEEP);
   // watchdog idles until the mode strap has been caught
   assign active  = q_ff.mode_taken && wd_active(q_ff.mode, sw_watchdog_enable, asleep);
   assign last    = ratio_last(ps);
   assign timeout = active && tick && (q_ff.cnt == last);
   assign pending = |(core_in.irq_enable_vec & core_in.irq_flag_vec);
   assign wr_fire = q_ff.aw_full && q_ff.w_full && !q_ff.bvalid;
   assign ctl_wr  = wr_fire && (q_ff.aw_addr == WDSW_OFS_CTL);

   always_comb begin
      nxt_q = q_ff;
      ev_set = '0;
      ev_clr = '0;
      nxt_q.reset_req = 1'b0;
      nxt_q.wake = 1'b0;
      nxt_q.isr_after = 1'b0;
      // mode strap caught once after release, then frozen
      if (!q_ff.mode_taken) begin
         nxt_q.mode = watchdog_mode_cfg;
         nxt_q.mode_taken = 1'b1;
      end
      // oscillator inputs: three stages, level accepted when stages two and three agree
      nxt_q.lf_sync = {q_ff.lf_sync[1:0], low_freq_osc};
      nxt_q.mf_sync = {q_ff.mf_sync[1:0], mid_freq_osc};
      if (q_ff.lf_sync[1] == q_ff.lf_sync[2]) begin
         nxt_q.lf_filt = q_ff.lf_sync[2];
      end
      if (q_ff.mf_sync[1] == q_ff.mf_sync[2]) begin
         nxt_q.mf_filt = q_ff.mf_sync[2];
      end
      // axi write channels, taken in either order
      if (s_axi_awvalid && !q_ff.aw_full) begin
         nxt_q.aw_full = 1'b1;
         nxt_q.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q_ff.w_full) begin
         nxt_q.w_full = 1'b1;
         nxt_q.wdata = s_axi_wdata;
         nxt_q.wstrb = s_axi_wstrb;
      end
      if (q_ff.bvalid && s_axi_bready) begin
         nxt_q.bvalid = 1'b0;
      end
      if (wr_fire) begin
         nxt_q.aw_full = 1'b0;
         nxt_q.w_full = 1'b0;
         nxt_q.bvalid = 1'b1;
         nxt_q.bresp = is_mapped(q_ff.aw_addr) ? WDSW_RESP_OKAY : WDSW_RESP_SLVERR;
         if (ctl_wr && q_ff.wstrb[0]) begin
            nxt_q.ctl = q_ff.wdata[7:0] & WDSW_CTL_MASK;
         end
         if (q_ff.aw_addr == WDSW_OFS_STATUS && q_ff.wstrb[0]) begin
            // writing ones re-arms the active-low flags
            if (q_ff.wdata[0]) begin
               nxt_q.flg.powerdown_flag_n = 1'b1;
            end
            if (q_ff.wdata[1]) begin
               nxt_q.flg.timeout_flag_n = 1'b1;
            end
            if (q_ff.wdata[2]) begin
               nxt_q.flg.watchdog_reset_flag_n = 1'b1;
            end
         end
         if (q_ff.aw_addr == WDSW_OFS_IRQ_CLR && q_ff.wstrb[0]) begin
            ev_clr = q_ff.wdata[WDSW_EV_W-1:0];
         end
         if (q_ff.aw_addr == WDSW_OFS_IRQ_EN && q_ff.wstrb[0]) begin
            nxt_q.ev_en = q_ff.wdata[WDSW_EV_W-1:0];
         end
      end
      // axi read
      if (q_ff.rvalid && s_axi_rready) begin
         nxt_q.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !q_ff.rvalid) begin
         nxt_q.rvalid = 1'b1;
         nxt_q.rresp = is_mapped(s_axi_araddr) ? WDSW_RESP_OKAY : WDSW_RESP_SLVERR;
         case (s_axi_araddr)
            WDSW_OFS_CTL:      nxt_q.rdata = {24'h000000, q_ff.ctl};
            WDSW_OFS_STATUS:   nxt_q.rdata = {26'h0, q_ff.mode, asleep,
                                              q_ff.flg.watchdog_reset_flag_n,
                                              q_ff.flg.timeout_flag_n,
                                              q_ff.flg.powerdown_flag_n};
            WDSW_OFS_IRQ_STAT: nxt_q.rdata = 32'(q_ff.ev_stat);
            WDSW_OFS_IRQ_EN:   nxt_q.rdata = 32'(q_ff.ev_en);
            WDSW_OFS_COUNT:    nxt_q.rdata = 32'(q_ff.cnt);
            default:           nxt_q.rdata = 32'h00000000;
         endcase
      end
      // power state and counter
      case (q_ff.pwr)
         WDSW_PWR_AWAKE: begin
            if (core_in.sleep_instruction && pending) begin
               ev_set[WDSW_EV_SLEEP_NOP] = 1'b1;
               // the sleep leaves the counter alone, a kick or write beside it still clears
               if (ctl_wr || core_in.kick_instruction) begin
                  nxt_q.cnt = '0;
               end
            end else if (core_in.sleep_instruction) begin
               nxt_q.pwr = WDSW_PWR_ASLEEP;
               nxt_q.flg.powerdown_flag_n = 1'b0;
               nxt_q.flg.timeout_flag_n = 1'b1;
               nxt_q.cnt = '0;
               ev_set[WDSW_EV_SLEEP] = 1'b1;
            end else if (timeout) begin
               nxt_q.reset_req = 1'b1;
               nxt_q.flg.watchdog_reset_flag_n = 1'b0;
               nxt_q.cnt = '0;
               ev_set[WDSW_EV_RESET] = 1'b1;
            end else if (ctl_wr || core_in.kick_instruction || !active) begin
               nxt_q.cnt = '0;
            end else if (tick) begin
               nxt_q.cnt = q_ff.cnt + 1'b1;
            end
         end
         WDSW_PWR_ASLEEP: begin
            if (timeout) begin
               // no reset from sleep: wake and report through the flags
               nxt_q.pwr = WDSW_PWR_WAKING;
               nxt_q.flg = '{timeout_flag_n: 1'b0, powerdown_flag_n: 1'b0,
                             watchdog_reset_flag_n: 1'b0};
               nxt_q.cnt = '0;
               ev_set[WDSW_EV_WD_WAKE] = 1'b1;
            end else if (pending) begin
               nxt_q.pwr = WDSW_PWR_WAKING;
               nxt_q.cnt = '0;
            end else if (ctl_wr || !active) begin
               nxt_q.cnt = '0;
            end else if (tick) begin
               nxt_q.cnt = q_ff.cnt + 1'b1;
            end
         end
         WDSW_PWR_WAKING: begin
            // execution continues; the global enable only decides the service call
            nxt_q.pwr = WDSW_PWR_AWAKE;
            nxt_q.wake = 1'b1;
            nxt_q.isr_after = core_in.global_irq_enable;
            nxt_q.cnt = '0;
         end
         default: begin
            nxt_q.pwr = WDSW_PWR_AWAKE;
            nxt_q.cnt = '0;
         end
      endcase
      // a new event wins over a clear in the same cycle
      nxt_q.ev_stat = (q_ff.ev_stat & ~ev_clr) | ev_set;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q_ff <= '{ctl: WDSW_CTL_RST, cnt: '0, pwr: WDSW_PWR_AWAKE,
                   flg: '{timeout_flag_n: 1'b1, powerdown_flag_n: 1'b1,
                          watchdog_reset_flag_n: 1'b1},
                   mode: WDSW_MODE_OFF, mode_taken: 1'b0,
                   lf_sync: '0, mf_sync: '0, lf_filt: 1'b0, mf_filt: 1'b0,
                   ev_stat: '0, ev_en: '0, reset_req: 1'b0, wake: 1'b0,
                   isr_after: 1'b0, aw_full: 1'b0, aw_addr: '0, w_full: 1'b0,
                   wdata: '0, wstrb: '0, bvalid: 1'b0, bresp: WDSW_RESP_OKAY,
                   rvalid: 1'b0, rdata: '0, rresp: WDSW_RESP_OKAY};
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign s_axi_awready = !q_ff.aw_full;
   assign s_axi_wready  = !q_ff.w_full;
   assign s_axi_bvalid  = q_ff.bvalid;
   assign s_axi_bresp   = q_ff.bresp;
   assign s_axi_arready = !q_ff.rvalid;
   assign s_axi_rvalid  = q_ff.rvalid;
   assign s_axi_rdata   = q_ff.rdata;
   assign s_axi_rresp   = q_ff.rresp;
   assign flags         = q_ff.flg;
   assign irq           = |(q_ff.ev_stat & q_ff.ev_en);
   // core clocks stop only while truly asleep
   assign core_out.device_reset_req = q_ff.reset_req;
   assign core_out.asleep           = asleep;
   assign core_out.cpu_clock_enable = !asleep;
   assign core_out.wake             = q_ff.wake;
   assign core_out.isr_after_next   = q_ff.isr_after;

   // helper: has software ever written the control register
   logic ctl_written_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_written_ff <= 1'b0;
      end else if (ctl_wr) begin
         ctl_written_ff <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_sleep_timeout;
      asleep && timeout;
   endsequence
   sequence s_wake_done;
      q_ff.wake && q_ff.pwr == WDSW_PWR_AWAKE && q_ff.cnt == '0 && !q_ff.reset_req;
   endsequence
   sequence s_sleep_enter;
      q_ff.pwr == WDSW_PWR_AWAKE && core_in.sleep_instruction && !pending;
   endsequence

   a_always_on_sleep: assert property (q_ff.mode_taken && q_ff.mode == WDSW_MODE_ALWAYS
      && asleep && tick && !timeout && !pending && !ctl_wr
      |=> q_ff.cnt == $past(q_ff.cnt) + 1'b1)
      else $error("always-on watchdog did not count in sleep");
   a_off_in_sleep: assert property (q_ff.mode == WDSW_MODE_AWAKE && asleep
      |=> q_ff.cnt == '0 && !q_ff.reset_req)
      else $error("awake-only watchdog ran in sleep");
   a_sw_enable_gate: assert property (q_ff.mode_taken && q_ff.mode == WDSW_MODE_SW
      && !sw_watchdog_enable |=> q_ff.cnt == '0)
      else $error("software-disabled watchdog counted");
   a_mode_off_idle: assert property (q_ff.mode_taken && q_ff.mode == WDSW_MODE_OFF
      |=> q_ff.cnt == '0 && !q_ff.reset_req)
      else $error("disabled watchdog counted");
   a_clock_select: assert property (active && !asleep && !ctl_wr
      && !core_in.sleep_instruction && !core_in.kick_instruction
      && !rising_tick(q_ff.lf_sync, q_ff.lf_filt) && !q_ff.ctl[WDSW_CTL_CS_BIT]
      |=> $stable(q_ff.cnt))
      else $error("counter advanced without a tick of the chosen oscillator");
   a_divide_ratio: assert property (timeout && ps <= WDSW_PS_MAX_CODE
      |-> q_ff.cnt == CNT_W'((WDSW_BASE_DIV << ps) - 1))
      else $error("timeout at wrong count");
   a_reserved_code: assert property (timeout && ps > WDSW_PS_MAX_CODE
      |-> q_ff.cnt == CNT_W'(WDSW_BASE_DIV - 1))
      else $error("reserved prescale did not give minimum ratio");
   a_ps_default: assert property (!ctl_written_ff
      |-> q_ff.ctl == WDSW_CTL_RST)
      else $error("control register lost its reset value");
   a_awake_reset: assert property (timeout && q_ff.pwr == WDSW_PWR_AWAKE
      && !core_in.sleep_instruction
      |=> q_ff.reset_req && !q_ff.flg.watchdog_reset_flag_n ##1 !q_ff.reset_req)
      else $error("awake timeout did not pulse a reset");
   a_kick_clear: assert property (q_ff.pwr == WDSW_PWR_AWAKE && core_in.kick_instruction
      |=> q_ff.cnt == '0)
      else $error("kick did not clear the counter");
   a_ctl_write_clear: assert property (ctl_wr |=> q_ff.cnt == '0)
      else $error("control write did not clear the counter");
   a_sleep_entry: assert property (s_sleep_enter |=> asleep && q_ff.cnt == '0
      && !q_ff.flg.powerdown_flag_n && q_ff.flg.timeout_flag_n
      && !core_out.cpu_clock_enable)
      else $error("sleep entry did not clear counter or set flags");
   a_wd_wake: assert property (s_sleep_timeout |=> q_ff.pwr == WDSW_PWR_WAKING
      && q_ff.flg == 3'b000 ##1 s_wake_done)
      else $error("sleep timeout did not wake cleanly");
   a_sleep_nop: assert property (q_ff.pwr == WDSW_PWR_AWAKE
      && core_in.sleep_instruction && pending
      |=> q_ff.pwr == WDSW_PWR_AWAKE && q_ff.flg == $past(q_ff.flg))
      else $error("sleep with pending interrupt was not a no-op");
   a_irq_wake: assert property (asleep && pending && !timeout
      |=> q_ff.pwr == WDSW_PWR_WAKING && q_ff.cnt == '0
      ##1 s_wake_done)
      else $error("interrupt did not wake the device");
   a_isr_select: assert property (q_ff.pwr == WDSW_PWR_WAKING
      |=> q_ff.wake && q_ff.isr_after == $past(core_in.global_irq_enable))
      else $error("service call choice wrong on wake");
   a_mode_frozen: assert property (q_ff.mode_taken |=> $stable(q_ff.mode))
      else $error("mode setting changed while running");

endmodule : wdsw_watchdog
`default_nettype wire

// *** verification/wdsw_core_model.sv ***
// processor core model issuing kick and sleep instructions
`timescale 1ns/1ns
`default_nettype none
module wdsw_core_model
   import wdsw_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       cpu_clock_enable,
   input  wire logic       auto_kick,
   input  wire logic       sleep_req,
   input  wire logic [2:0] irq_cfg,
   output wdsw_core_in_s   core_in
);
   logic [6:0] kick_cnt_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         kick_cnt_ff <= 7'h00;
         core_in     <= '0;
      end else begin
         kick_cnt_ff <= kick_cnt_ff + 7'h01;
         // kicks every 128 cycles, well inside the shortest timeout
         core_in.kick_instruction <= auto_kick && cpu_clock_enable && (kick_cnt_ff == 7'h00);
         // a stopped core issues nothing
         core_in.sleep_instruction <= sleep_req && cpu_clock_enable;
         core_in.global_irq_enable <= irq_cfg[2];
         core_in.irq_enable_vec    <= {7'h00, irq_cfg[1]};
         core_in.irq_flag_vec      <= {7'h00, irq_cfg[0]};
      end
   end
endmodule // wdsw_core_model
`default_nettype wire

// *** verification/wdsw_watchdog_tb.sv ***
// self-checking bench for the watchdog with sleep and wake
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin fails++; \
   $display("Error %s exp %h got %h", n, e, a); end end
module wdsw_watchdog_tb
   import wdsw_pkg::*;
;
   typedef struct packed {logic [1:0] m; logic [7:0] c; logic l, f, k, e;} wdsw_row_s;
   logic clk = 0, rst_n = 0, lf = 0, mf = 0, lf_on = 0, mf_on = 0, kick_on = 0, slp = 0;
   logic [1:0] mode = 0, div = 0, bresp, rresp, rsp;
   logic [2:0] icfg = 0, seen;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rdat;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   wdsw_core_in_s  cin;
   wdsw_core_out_s cout;
   wdsw_flags_s    flg;
   int fails = 0, check_count = 0;
   wdsw_row_s rows[10] = '{
      '{2'h0, 8'h01, 1'b1, 1'b0, 1'b0, 1'b0},
      '{2'h1, 8'h01, 1'b1, 1'b0, 1'b0, 1'b1},
      '{2'h1, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0},
      '{2'h2, 8'h01, 1'b1, 1'b0, 1'b0, 1'b1},
      '{2'h3, 8'h00, 1'b1, 1'b0, 1'b0, 1'b1},
      '{2'h3, 8'h27, 1'b1, 1'b0, 1'b0, 1'b1},
      '{2'h3, 8'h03, 1'b1, 1'b0, 1'b0, 1'b0},
      '{2'h3, 8'h81, 1'b0, 1'b1, 1'b0, 1'b1},
      '{2'h3, 8'h01, 1'b0, 1'b1, 1'b0, 1'b0},
      '{2'h3, 8'h01, 1'b1, 1'b0, 1'b1, 1'b0}};

   always #25 clk = ~clk;
   // both oscillators run slow: 4 clk per phase, a tick each 8 clk
   always @(posedge clk) begin
      div <= div + 2'h1;
      if (div == 2'h3) begin
         if (lf_on) lf <= ~lf;
         if (mf_on) mf <= ~mf;
      end
   end

   wdsw_core_model core_u (.clk(clk), .rst_n(rst_n), .cpu_clock_enable(cout.cpu_clock_enable),
      .auto_kick(kick_on), .sleep_req(slp), .irq_cfg(icfg), .core_in(cin));
   wdsw_watchdog #(.CNT_W(24)) dut_u (.clk(clk), .rst_n(rst_n), .watchdog_mode_cfg(mode),
      .low_freq_osc(lf), .mid_freq_osc(mf), .core_in(cin), .core_out(cout), .flags(flg),
      .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   task automatic do_reset(input logic [1:0] m);
      rst_n <= 1'b0; mode <= m; lf_on <= 1'b0; mf_on <= 1'b0; kick_on <= 1'b0; icfg <= 3'h0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rsp = bresp; bready <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [11:0] a);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rdat = rdata; rsp = rresp; rready <= 1'b0;
      @(posedge clk);
   endtask
   // bit0 reset request, bit1 wake, bit2 service call after wake
   task automatic watch(input int n);
      seen = 3'h0;
      repeat (n) begin
         @(posedge clk);
         if (cout.device_reset_req === 1'b1) seen[0] = 1'b1;
         if (cout.wake === 1'b1) seen[2:1] = {cout.isr_after_next, 1'b1};
      end
   endtask
   task automatic sleep_pulse;
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic finish_test;
      if (fails == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      finish_test();
   end

   initial begin
      do_reset(2'h3);
      rd(WDSW_OFS_CTL); `CHK("ctl_reset", 32'h16, rdat)
      rd(12'h900); `CHK("unmapped", 2'h2, rsp)
      wr(12'h900, 32'h0); `CHK("unmapped_w", WDSW_RESP_SLVERR, rsp)
      foreach (rows[i]) begin
         do_reset(rows[i].m);
         kick_on <= rows[i].k;
         wr(WDSW_OFS_CTL, {24'h0, rows[i].c});
         lf_on <= rows[i].l; mf_on <= rows[i].f;
         rd(WDSW_OFS_CTL); `CHK("ctl", {24'h0, rows[i].c}, rdat)
         watch(400); `CHK("reset_req", rows[i].e, seen[0])
         rd(WDSW_OFS_IRQ_STAT); `CHK("ev_reset", 32'(rows[i].e), rdat)
      end
      // always-on: sleep timeout wakes instead of resetting
      do_reset(2'h3);
      wr(WDSW_OFS_IRQ_EN, 32'h4);
      wr(WDSW_OFS_CTL, 32'h1);
      lf_on <= 1'b1;
      sleep_pulse();
      `CHK("asleep", 1'b1, cout.asleep)
      `CHK("cpu_clk", 1'b0, cout.cpu_clock_enable)
      `CHK("flags_sleep", 3'b101, flg)
      watch(350); `CHK("sleep_wd", 3'b010, seen)
      `CHK("flags_wd", 3'b000, flg)
      rd(WDSW_OFS_STATUS); `CHK("status_wd", 32'h30, rdat)
      wr(WDSW_OFS_STATUS, 32'h7); `CHK("flags_rearm", 3'b111, flg)
      wr(WDSW_OFS_CTL, 32'h1);
      `CHK("irq_set", 1'b1, irq)
      wr(WDSW_OFS_IRQ_EN, 32'h0); `CHK("irq_mask", 1'b0, irq)
      wr(WDSW_OFS_IRQ_EN, 32'h4); `CHK("irq_unmask", 1'b1, irq)
      wr(WDSW_OFS_IRQ_CLR, 32'h4); `CHK("irq_clr", 1'b0, irq)
      rd(WDSW_OFS_IRQ_STAT); `CHK("ev_wd", 32'h2, rdat)
      // awake-only mode: pending interrupt, then sleep without watchdog
      do_reset(2'h2);
      icfg <= 3'b011;
      sleep_pulse();
      `CHK("nop_asleep", 1'b0, cout.asleep)
      `CHK("nop_flags", 3'b111, flg)
      rd(WDSW_OFS_IRQ_STAT); `CHK("ev_nop", 32'h8, rdat)
      icfg <= 3'b000;
      wr(WDSW_OFS_CTL, 32'h1);
      lf_on <= 1'b1;
      sleep_pulse();
      watch(600); `CHK("sleep_off", 3'b000, seen)
      `CHK("still_asleep", 1'b1, cout.asleep)
      rd(WDSW_OFS_COUNT); `CHK("cnt_sleep", 32'h0, rdat)
      icfg <= 3'b111;
      watch(10); `CHK("irq_wake", 3'b110, seen)
      `CHK("flags_irq", 3'b101, flg)
      finish_test();
   end
endmodule // wdsw_watchdog_tb
`default_nettype wire
